// ==== albp_pkg.sv ====
package albp_pkg;

   // Register locations (lower sixteen address bits)
   localparam logic [15:0] ALBP_DIR_OFFSET   = 16'hFFC0;
   localparam logic [15:0] ALBP_LATCH_OFFSET = 16'hFFC2;

   // Reset values and fixed read/direction values
   localparam logic [7:0] ALBP_DIR_RESET     = 8'h00;
   localparam logic [7:0] ALBP_LATCH_RESET   = 8'h00;
   localparam logic [7:0] ALBP_ALL_ONES      = 8'hFF;
   localparam logic [7:0] ALBP_UNMAPPED_READ = 8'h00;

   // Mode codes on the mode inputs
   localparam logic [2:0] ALBP_MODE_ADDR_LAST = 3'h4;
   localparam logic [2:0] ALBP_MODE_MIXED     = 3'h5;
   localparam logic [2:0] ALBP_MODE_RESET     = 3'h7;

   typedef enum logic [2:0] {
      ALBP_GRP_ADDR  = 3'b001,
      ALBP_GRP_MIXED = 3'b010,
      ALBP_GRP_GPIO  = 3'b100
   } albp_group_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } albp_bus_req_type;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } albp_pin_drive_type;

endpackage

// ==== albp_port.sv ====
//Contract
//- Modes 1 to 4: all eight pins output address bits 7..0 automatically.
//- Modes 1 to 4: direction bits fixed at one, writes ignored.
//- Mode 5: direction one drives address bit, zero is general input.
//- Modes 6 and 7: direction one is general output, zero is input.
//- Modes 5 to 7: direction register write-only, reads return all ones.
//- Reset and hardware standby clear direction; modes 1 to 4 read ones.
//- Software standby keeps direction and keeps output pins driving.
//- Data latch is 8-bit read/write; bit n drives pin n.
//- Read gives latch bit for outputs, pin level for inputs.
//- Data latch clears on reset and hardware standby, kept in software standby.
//- Direction register at FFC0 hex, data latch at FFC2 hex.
//- With DRAM in area 3, pins carry row then column addresses.
//- Each direction bit sets the role of the same-index pin.
//
// Local design decision: the address-low-byte port.
module albp_port
   import albp_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // Mode and standby
   input  wire logic [2:0]       mode_pins,
   input  wire logic             hw_standby,
   // Register port
   input  wire albp_bus_req_type bus_req,
   output logic [7:0]            rdata,
   // Address from bus controller (row/column already multiplexed)
   input  wire logic [WIDTH-1:0] low_address_lines,
   // Pins
   input  wire logic [WIDTH-1:0] low_port_pins_in,
   output logic [WIDTH-1:0]      low_port_pins_out,
   output logic [WIDTH-1:0]      low_port_pins_oe
);

   ////////////////////////////////////////////////////////////////////////
   // Mode capture

   logic           cap_done_q, cap_done_d;
   logic [2:0]     mode_q, mode_d;
   albp_group_type grp;

   // Async reset may only load a constant; the straps are caught on the
   // first clock after release and then frozen.
   always_comb begin
      cap_done_d = 1'b1;
      mode_d     = cap_done_q ? mode_q : mode_pins;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cap_done_q <= 1'b0;
         mode_q     <= ALBP_MODE_RESET;
      end else begin
         cap_done_q <= cap_done_d;
         mode_q     <= mode_d;
      end
   end

   always_comb begin
      if (mode_q <= ALBP_MODE_ADDR_LAST) begin
         grp = ALBP_GRP_ADDR;
      end else if (mode_q == ALBP_MODE_MIXED) begin
         grp = ALBP_GRP_MIXED;
      end else begin
         grp = ALBP_GRP_GPIO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   logic [WIDTH-1:0] dir_q, dir_d;
   logic [WIDTH-1:0] latch_q, latch_d;
   logic [WIDTH-1:0] dir_eff;
   logic             hit_dir, hit_latch;

   assign hit_dir   = (bus_req.addr == ALBP_DIR_OFFSET);
   assign hit_latch = (bus_req.addr == ALBP_LATCH_OFFSET);

   // Software standby needs no special handling: nothing here clears
   // the state except reset and hardware standby.
   always_comb begin
      dir_d   = dir_q;
      latch_d = latch_q;
      if (hw_standby) begin
         dir_d   = ALBP_DIR_RESET[WIDTH-1:0];
         latch_d = ALBP_LATCH_RESET[WIDTH-1:0];
      end else begin
         if (bus_req.wr && hit_dir && grp != ALBP_GRP_ADDR) begin
            dir_d = bus_req.wdata[WIDTH-1:0];
         end
         if (bus_req.wr && hit_latch) begin
            latch_d = bus_req.wdata[WIDTH-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         dir_q   <= ALBP_DIR_RESET[WIDTH-1:0];
         latch_q <= ALBP_LATCH_RESET[WIDTH-1:0];
      end else begin
         dir_q   <= dir_d;
         latch_q <= latch_d;
      end
   end

   // Address modes see all ones regardless of what is stored
   assign dir_eff = (grp == ALBP_GRP_ADDR) ? ALBP_ALL_ONES[WIDTH-1:0] : dir_q;

   ////////////////////////////////////////////////////////////////////////
   // Read path

   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   always_comb begin
      rdata_d = ALBP_UNMAPPED_READ;
      if (bus_req.rd) begin
         if (hit_dir) begin
            rdata_d = ALBP_ALL_ONES;
         end else if (hit_latch) begin
            rdata_d = 8'h00;
            rdata_d[WIDTH-1:0] = (dir_eff & latch_q) | (~dir_eff & low_port_pins_in);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin drive

   albp_pin_drive_type drv_d, drv_q;

   // Registered output adds one cycle from address to pin; the bus
   // controller presents the address a cycle ahead to compensate.
   always_comb begin
      drv_d = '0;
      for (int i = 0; i < WIDTH; i++) begin
         drv_d.oe[i] = dir_eff[i];
         unique case (grp)
            ALBP_GRP_ADDR:  drv_d.out[i] = low_address_lines[i];
            ALBP_GRP_MIXED: drv_d.out[i] = low_address_lines[i];
            ALBP_GRP_GPIO:  drv_d.out[i] = latch_q[i];
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         drv_q <= '0;
      end else begin
         drv_q <= drv_d;
      end
   end

   assign low_port_pins_out = drv_q.out[WIDTH-1:0];
   assign low_port_pins_oe  = drv_q.oe[WIDTH-1:0];

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_dir_write;
      bus_req.wr && hit_dir && !hw_standby;
   endsequence

   AST_ADDR_ALL_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
      (grp == ALBP_GRP_ADDR && cap_done_q) |=> (low_port_pins_oe == {WIDTH{1'b1}}))
      else $error("address mode pin not driven");

   AST_ADDR_DIR_LOCK: assert property (@(posedge sys_clk) disable iff (!resetn)
      (grp == ALBP_GRP_ADDR) |-> (dir_eff == {WIDTH{1'b1}}))
      else $error("address mode direction not all ones");

   AST_MIXED_ADDR: assert property (@(posedge sys_clk) disable iff (!resetn)
      (grp == ALBP_GRP_MIXED && $stable(grp)) |=>
      (low_port_pins_oe == $past(dir_q)) && ((low_port_pins_out & low_port_pins_oe) ==
      ($past(low_address_lines) & low_port_pins_oe)))
      else $error("mixed mode pin drive wrong");

   AST_GPIO_OUT: assert property (@(posedge sys_clk) disable iff (!resetn)
      (grp == ALBP_GRP_GPIO && $stable(grp)) |=> (low_port_pins_out == $past(latch_q)))
      else $error("gpio output not from latch");

   AST_DIR_READ_ONES: assert property (@(posedge sys_clk) disable iff (!resetn)
      (bus_req.rd && hit_dir) |=> (rdata == 8'hFF))
      else $error("direction read not all ones");

   AST_HWSTBY_CLEAR: assert property (@(posedge sys_clk) disable iff (!resetn)
      hw_standby |=> (dir_q == '0) && (latch_q == '0))
      else $error("hardware standby did not clear");

   AST_DIR_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
      (s_dir_write and (grp != ALBP_GRP_ADDR)) |=> (dir_q == $past(bus_req.wdata[WIDTH-1:0]))
      ##1 (hw_standby || (bus_req.wr && hit_dir) || (dir_q == $past(dir_q))))
      else $error("direction write lost or not held");

   AST_PORT_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
      (bus_req.rd && hit_latch) |=> (rdata[WIDTH-1:0] ==
      (($past(dir_eff) & $past(latch_q)) | (~$past(dir_eff) & $past(low_port_pins_in)))))
      else $error("port read mixes latch and pins wrongly");

   AST_MODE_HELD: assert property (@(posedge sys_clk) disable iff (!resetn)
      cap_done_q |=> $stable(mode_q))
      else $error("mode changed after capture");

   ////////////////////////////////////////////////////////////////////////
   // Further checks

   // Multi-step behaviours are built from these
   sequence s_latch_write;
      bus_req.wr && hit_latch && !hw_standby;
   endsequence

   sequence s_other_read;
      bus_req.rd && !hit_dir && !hit_latch;
   endsequence

   sequence s_standby_gpio;
      hw_standby && (grp != ALBP_GRP_ADDR);
   endsequence

   AST_LATCH_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_latch_write
      |=> (latch_q == $past(bus_req.wdata[WIDTH-1:0])))
      else $error("latch write lost");

   AST_LATCH_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!hw_standby && !(bus_req.wr && hit_latch))
      |=> $stable(latch_q))
      else $error("latch changed without write");

   // Address modes must ignore writes, or a later mode change would expose them
   AST_DIR_ADDR_NOWRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
      ((grp == ALBP_GRP_ADDR) && !hw_standby)
      |=> $stable(dir_q))
      else $error("direction changed in address mode");

   AST_ADDR_VALUE: assert property (@(posedge sys_clk) disable iff (!resetn)
      ((grp == ALBP_GRP_ADDR) && $stable(grp))
      |=> (low_port_pins_out == $past(low_address_lines)))
      else $error("address mode pin value wrong");

   AST_GPIO_OE: assert property (@(posedge sys_clk) disable iff (!resetn)
      ((grp == ALBP_GRP_GPIO) && $stable(grp))
      |=> (low_port_pins_oe == $past(dir_q)))
      else $error("gpio pin enable not from direction");

   AST_MIXED_INPUT: assert property (@(posedge sys_clk) disable iff (!resetn)
      ((grp == ALBP_GRP_MIXED) && $stable(grp))
      |=> ((low_port_pins_oe & ~$past(dir_q)) == '0))
      else $error("mixed mode input pin driven");

   AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_other_read
      |=> (rdata == ALBP_UNMAPPED_READ))
      else $error("unmapped read not zero");

   // Read data stand for one cycle only, so stale data cannot be taken twice
   AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!resetn)
      !bus_req.rd
      |=> (rdata == 8'h00))
      else $error("read data without read");

   AST_MODE_CAPTURE: assert property (@(posedge sys_clk) disable iff (!resetn)
      !cap_done_q
      |=> (mode_q == $past(mode_pins)))
      else $error("mode not taken from straps");

   AST_CAP_DONE: assert property (@(posedge sys_clk) disable iff (!resetn)
      cap_done_q
      |=> cap_done_q)
      else $error("mode capture reopened");

   // Two edges: one to clear the register, one to reach the pin flops
   AST_STANDBY_RELEASE: assert property (@(posedge sys_clk) disable iff (!resetn)
      s_standby_gpio
      |-> ##2 (low_port_pins_oe == '0))
      else $error("pins still driven after hardware standby");

endmodule // albp_port

// ==== albp_pin_model.sv ====
module albp_pin_model (
   // Device side
   input  wire logic [7:0] pins_out,
   input  wire logic [7:0] pins_oe,
   // Level forced by the external loads
   input  wire logic [7:0] ext_level,
   // Resolved wire
   output logic [7:0]      pins_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Loads only win where the port has let go of the pin
   assign pins_level = (pins_oe & pins_out) | (~pins_oe & ext_level);
endmodule // albp_pin_model

// ==== albp_port_tb.sv ====
module albp_port_tb
   import albp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             sys_clk;
   logic             resetn;
   logic [2:0]       mode_pins;
   logic             hw_standby;
   albp_bus_req_type bus_req;
   logic [7:0]       rdata;
   logic [7:0]       addr_lines;
   logic [7:0]       pins_in;
   logic [7:0]       pins_out;
   logic [7:0]       pins_oe;
   logic [7:0]       ext_level;
   int               err_total;
   int               tests_run;
   int               cyc;

   albp_port i_albp_port (.sys_clk(sys_clk), .resetn(resetn), .mode_pins(mode_pins), .hw_standby(hw_standby),
      .bus_req(bus_req), .rdata(rdata), .low_address_lines(addr_lines), .low_port_pins_in(pins_in),
      .low_port_pins_out(pins_out), .low_port_pins_oe(pins_oe));
   albp_pin_model i_albp_pin_model (.pins_out(pins_out), .pins_oe(pins_oe), .ext_level(ext_level),
      .pins_level(pins_in));

   ////////////////////////////////////////////////////////////////////////////
   always #12.5 sys_clk = ~sys_clk;

   task automatic print_verdict();
      $display("errors %0d, checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard, well above the roughly 75 cycles needed
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   // Output bits are compared only where the pin is driven
   task automatic pins(input logic [7:0] e_oe, input logic [7:0] e_out);
      repeat (2) @(posedge sys_clk);
      #1 chk(pins_oe, e_oe);
      chk(pins_out & e_oe, e_out & e_oe);
   endtask

   task automatic do_reset(input logic [2:0] m);
      resetn <= 1'b0;
      mode_pins <= m;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      mode_pins = 3'h6;
      hw_standby = 1'b0;
      bus_req = '0;
      addr_lines = 8'hC3;
      ext_level = 8'hA5;
      do_reset(3'h6);
      pins(8'h00, 8'h00);
      rd(ALBP_DIR_OFFSET, 8'hFF);
      rd(ALBP_LATCH_OFFSET, 8'hA5);
      wr(ALBP_LATCH_OFFSET, 8'h3C);
      wr(ALBP_DIR_OFFSET, 8'h0F);
      pins(8'h0F, 8'h3C);
      rd(ALBP_LATCH_OFFSET, 8'hAC);
      rd(ALBP_DIR_OFFSET, 8'hFF);
      rd(16'hFFC4, 8'h00);
      @(posedge sys_clk);
      hw_standby <= 1'b1;
      @(posedge sys_clk);
      hw_standby <= 1'b0;
      pins(8'h00, 8'h00);
      rd(ALBP_LATCH_OFFSET, 8'hA5);
      do_reset(3'h5);
      pins(8'h00, 8'h00);
      wr(ALBP_LATCH_OFFSET, 8'h00);
      wr(ALBP_DIR_OFFSET, 8'h81);
      pins(8'h81, 8'hC3);
      do_reset(3'h2);
      mode_pins <= 3'h6;
      wr(ALBP_DIR_OFFSET, 8'h00);
      pins(8'hFF, 8'hC3);
      rd(ALBP_DIR_OFFSET, 8'hFF);
      print_verdict();
   end
endmodule // albp_port_tb
